// ### design/acr_cfg.svh
// Register map constants for the channel calibration bank.
// Assumes 32-bit Wishbone data with one 16-bit register per aligned word.
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Register indices; the byte address is four times the index
`define ACR_IDX_CH2_OFS_HIGH 6'h14
`define ACR_IDX_CH2_OFS_LOW  6'h15
`define ACR_IDX_CH2_GAIN_HI  6'h16
`define ACR_IDX_CH2_GAIN_LO  6'h17
`define ACR_IDX_CH3_CONFIG   6'h18
`define ACR_IDX_CH3_OFS_HIGH 6'h19

// Writable bit masks; cleared bits are reserved
`define ACR_MASK_FULL        16'hFFFF
`define ACR_MASK_LOW         16'hFF00
`define ACR_MASK_CONFIG      16'hFFC7

// Reset values
`define ACR_RST_ZERO         16'h0000
`define ACR_RST_GAIN_HI      16'h8000
`define ACR_RST_GAIN_WORD    24'h800000

// Field positions in the configuration register
`define ACR_CFG_PHASE_MSB    15
`define ACR_CFG_PHASE_LSB    6
`define ACR_CFG_DC_OFF_BIT   2
`define ACR_CFG_SEL_MSB      1
`define ACR_CFG_SEL_LSB      0

// Field position of the lower byte of a correction word
`define ACR_LOW_BYTE_MSB     15
`define ACR_LOW_BYTE_LSB     8

`endif

// ### design/acr_pkg.sv
// Types shared by the channel calibration bank.
// Assumes acr_cfg.svh supplies the numeric constants.
package acr_pkg;

   typedef enum logic [1:0] {
      ACR_IN_PINS,
      ACR_IN_SHORTED,
      ACR_IN_TEST_POS,
      ACR_IN_TEST_NEG
   } acr_input_sel_t;

   typedef logic [15:0] acr_word_t;

   localparam int ACR_NUM_REGS = 6;

endpackage

// ### design/acr_regs.sv
// Calibration and configuration registers for channel 2 and part of channel 3.
// Assumes a classic Wishbone master on the same clock and a downstream filter.
// How it works
// - Offset high register holds offset bits 23:8
// - Offset low register bits 15:8 hold bits 7:0
// - Reserved bits ignore writes, read as zero
// - Gain correction is unsigned, never sign extended
// - Gain split: high 23:8, low 15:8 holds 7:0
// - Channel 2 gain resets to 8000h, low zero
// - Config bits 15:6 hold signed phase delay
// - Config bit 2 disables DC block per channel
// - Config bits 1:0 choose the channel input
// - Decode listed addresses, each resetting to 0000h except gain high (8000h)
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "acr_cfg.svh"

module acr_regs
   import acr_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic             O_WB_ACK,
   output logic [31:0]      O_WB_DAT,
   output logic [23:0]      O_CH2_OFFSET,
   output logic [23:0]      O_CH2_GAIN,
   output logic [15:0]      O_CH3_OFFSET_HIGH,
   output logic [9:0]       O_CH3_PHASE_DELAY,
   output logic             O_CH3_DC_BLOCK_OFF,
   output acr_input_sel_t   O_CH3_INPUT_SELECT
);

   localparam logic [5:0] IDX [ACR_NUM_REGS] = '{
      `ACR_IDX_CH2_OFS_HIGH, `ACR_IDX_CH2_OFS_LOW, `ACR_IDX_CH2_GAIN_HI,
      `ACR_IDX_CH2_GAIN_LO, `ACR_IDX_CH3_CONFIG, `ACR_IDX_CH3_OFS_HIGH};
   localparam acr_word_t MASK [ACR_NUM_REGS] = '{
      `ACR_MASK_FULL, `ACR_MASK_LOW, `ACR_MASK_FULL,
      `ACR_MASK_LOW, `ACR_MASK_CONFIG, `ACR_MASK_FULL};
   localparam acr_word_t RST [ACR_NUM_REGS] = '{
      `ACR_RST_ZERO, `ACR_RST_ZERO, `ACR_RST_GAIN_HI,
      `ACR_RST_ZERO, `ACR_RST_ZERO, `ACR_RST_ZERO};

   acr_word_t   regs      [ACR_NUM_REGS];
   acr_word_t   next_regs [ACR_NUM_REGS];
   logic        ack;
   logic        next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [5:0]  idx;
   logic        req;
   logic        wr_go;
   logic        rd_go;
   acr_word_t   lane_mask;
   acr_word_t   hit_word;
   logic        hit;

   // Byte address bits 1:0 are ignored; one register per word
   assign idx       = I_WB_ADR[7:2];
   // Accept once per request; ack drops the cycle after it is given
   assign req       = I_WB_CYC & I_WB_STB & ~ack;
   assign wr_go     = req & I_WB_WE;
   assign rd_go     = req & ~I_WB_WE;
   assign lane_mask = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

   // Register storage, one write port per register
   generate
      for (genvar g = 0; g < ACR_NUM_REGS; g++) begin : g_reg
         always_comb begin
            next_regs[g] = regs[g];
            if (wr_go && idx == IDX[g]) begin
               // Reserved bits and unselected lanes keep their value
               next_regs[g] = (regs[g] & ~(MASK[g] & lane_mask))
                            | (I_WB_DAT[15:0] & MASK[g] & lane_mask);
            end
         end

         always_ff @(posedge I_CLK) begin
            if (I_RESET) begin
               regs[g] <= RST[g];
            end else begin
               regs[g] <= next_regs[g];
            end
         end
      end
   endgenerate

   // Read mux; unmapped addresses answer with zero
   always_comb begin
      hit_word = 16'h0000;
      hit      = 1'b0;
      for (int k = 0; k < ACR_NUM_REGS; k++) begin
         if (idx == IDX[k]) begin
            hit_word = regs[k] & MASK[k];
            hit      = 1'b1;
         end
      end
   end

   always_comb begin
      next_ack   = req;
      next_rdata = rdata;
      if (rd_go) begin
         // Upper half zero: unsigned fields are never sign extended
         next_rdata = hit ? {16'h0000, hit_word} : 32'h00000000;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         ack   <= 1'b0;
         rdata <= 32'h00000000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign O_WB_ACK = ack;
   assign O_WB_DAT = rdata;

   // Correction words; halves apply the moment each is written
   assign O_CH2_OFFSET = {regs[0],
                          regs[1][`ACR_LOW_BYTE_MSB:`ACR_LOW_BYTE_LSB]};
   // Unsigned gain: code * 2 / 2^24, so 800000h is unity
   assign O_CH2_GAIN   = {regs[2],
                          regs[3][`ACR_LOW_BYTE_MSB:`ACR_LOW_BYTE_LSB]};
   assign O_CH3_OFFSET_HIGH  = regs[5];
   assign O_CH3_PHASE_DELAY  = regs[4][`ACR_CFG_PHASE_MSB:`ACR_CFG_PHASE_LSB];
   assign O_CH3_DC_BLOCK_OFF = regs[4][`ACR_CFG_DC_OFF_BIT];
   assign O_CH3_INPUT_SELECT =
      acr_input_sel_t'(regs[4][`ACR_CFG_SEL_MSB:`ACR_CFG_SEL_LSB]);

   // Checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   logic full_wr;
   assign full_wr = wr_go & (I_WB_SEL[1:0] == 2'b11);

   // Two unanswered cycles would mean a lost ack; saturates rather than wraps
   logic [1:0] wait_cnt;
   logic [1:0] next_wait_cnt;

   always_comb begin
      next_wait_cnt = wait_cnt;
      if (!(I_WB_CYC && I_WB_STB) || ack) begin
         next_wait_cnt = 2'h0;
      end else if (wait_cnt != 2'h3) begin
         next_wait_cnt = wait_cnt + 2'h1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         wait_cnt <= 2'h0;
      end else begin
         wait_cnt <= next_wait_cnt;
      end
   end

   sequence req_s;
      I_WB_CYC && I_WB_STB && !ack;
   endsequence

   sequence answer_s;
      ack ##1 !ack;
   endsequence

   property handshake_p;
      req_s |=> answer_s;
   endproperty

   offset_high_a: assert property (
      (full_wr && idx == `ACR_IDX_CH2_OFS_HIGH)
      |=> O_CH2_OFFSET[23:8] == $past(I_WB_DAT[15:0]))
      else $error("Offset high half not stored");

   offset_low_a: assert property (
      (full_wr && idx == `ACR_IDX_CH2_OFS_LOW)
      |=> O_CH2_OFFSET[7:0] == $past(I_WB_DAT[15:8]))
      else $error("Offset low byte not stored");

   reserved_zero_a: assert property (
      (rd_go && (idx == `ACR_IDX_CH2_OFS_LOW || idx == `ACR_IDX_CH2_GAIN_LO))
      |=> O_WB_ACK && O_WB_DAT[7:0] == 8'h00)
      else $error("Reserved low byte not zero");

   reserved_cfg_a: assert property (
      (rd_go && idx == `ACR_IDX_CH3_CONFIG)
      |=> O_WB_DAT[5:3] == 3'h0 && O_WB_DAT[31:16] == 16'h0000)
      else $error("Reserved config bits not zero");

   gain_unsigned_a: assert property (
      (rd_go && idx == `ACR_IDX_CH2_GAIN_HI)
      |=> O_WB_DAT == {16'h0000, O_CH2_GAIN[23:8]})
      else $error("Gain read back sign extended");

   gain_low_a: assert property (
      (full_wr && idx == `ACR_IDX_CH2_GAIN_LO)
      |=> O_CH2_GAIN[7:0] == $past(I_WB_DAT[15:8])
          && $stable(O_CH2_GAIN[23:8]))
      else $error("Gain low byte misplaced");

   gain_reset_a: assert property (
      $past(I_RESET) |-> O_CH2_GAIN == `ACR_RST_GAIN_WORD)
      else $error("Gain not unity after reset");

   phase_field_a: assert property (
      (full_wr && idx == `ACR_IDX_CH3_CONFIG)
      |=> O_CH3_PHASE_DELAY == $past(I_WB_DAT[15:6]))
      else $error("Phase delay not stored");

   dc_block_a: assert property (
      (full_wr && idx == `ACR_IDX_CH3_CONFIG)
      |=> O_CH3_DC_BLOCK_OFF == $past(I_WB_DAT[2]))
      else $error("DC block bit not stored");

   input_sel_a: assert property (
      (full_wr && idx == `ACR_IDX_CH3_CONFIG)
      |=> O_CH3_INPUT_SELECT == acr_input_sel_t'($past(I_WB_DAT[1:0])))
      else $error("Input select not stored");

   bus_answer_a: assert property (handshake_p)
      else $error("Ack not single cycle after request");

   unmapped_a: assert property (
      (rd_go && !hit) |=> O_WB_DAT == 32'h00000000)
      else $error("Unmapped read not zero");

   halves_apart_a: assert property (
      (wr_go && idx == `ACR_IDX_CH2_OFS_HIGH)
      |=> $stable(O_CH2_OFFSET[7:0]))
      else $error("Low half changed by high write");

   ack_latency_a: assert property (
      wait_cnt <= 2'h1)
      else $error("Request left waiting for ack");

   ack_cause_a: assert property (
      O_WB_ACK |-> $past(req))
      else $error("Ack without a request");

   read_hold_a: assert property (
      !rd_go |=> $stable(O_WB_DAT))
      else $error("Read data changed without a read");

   bus_reset_a: assert property (
      $past(I_RESET) |-> !O_WB_ACK && O_WB_DAT == 32'h00000000)
      else $error("Bus outputs not idle after reset");

   offset_reset_a: assert property (
      $past(I_RESET)
      |-> O_CH2_OFFSET == 24'h000000 && O_CH3_OFFSET_HIGH == `ACR_RST_ZERO)
      else $error("Offsets not zero after reset");

   config_reset_a: assert property (
      $past(I_RESET)
      |-> O_CH3_PHASE_DELAY == 10'h000 && !O_CH3_DC_BLOCK_OFF
          && O_CH3_INPUT_SELECT == ACR_IN_PINS)
      else $error("Config fields not default after reset");

   reserved_store_a: assert property (
      regs[1][7:0] == 8'h00 && regs[3][7:0] == 8'h00 && regs[4][5:3] == 3'h0)
      else $error("Reserved bits hold a written value");

   gain_high_a: assert property (
      (full_wr && idx == `ACR_IDX_CH2_GAIN_HI)
      |=> O_CH2_GAIN[23:8] == $past(I_WB_DAT[15:0]))
      else $error("Gain high half not stored");

   ch3_offset_a: assert property (
      (full_wr && idx == `ACR_IDX_CH3_OFS_HIGH)
      |=> O_CH3_OFFSET_HIGH == $past(I_WB_DAT[15:0]))
      else $error("Channel 3 offset high not stored");

   offset_lane_a: assert property (
      (wr_go && idx == `ACR_IDX_CH2_OFS_LOW && I_WB_SEL[1])
      |=> O_CH2_OFFSET[7:0] == $past(I_WB_DAT[15:8]))
      else $error("Offset low lane not stored");

   lane_keep_a: assert property (
      (wr_go && idx == `ACR_IDX_CH2_GAIN_HI && I_WB_SEL[1:0] == 2'h1)
      |=> $stable(O_CH2_GAIN[23:16]) && O_CH2_GAIN[15:8] == $past(I_WB_DAT[7:0]))
      else $error("Unselected gain lane written");

   // Upper lane alone must leave the input routing untouched
   sequence cfg_upper_s;
      wr_go && idx == `ACR_IDX_CH3_CONFIG && I_WB_SEL[1:0] == 2'h2;
   endsequence

   sequence cfg_lower_kept_s;
      $stable(O_CH3_INPUT_SELECT) && $stable(O_CH3_DC_BLOCK_OFF);
   endsequence

   cfg_lane_a: assert property (
      cfg_upper_s |=> cfg_lower_kept_s)
      else $error("Upper lane write moved input select");

   unmapped_write_a: assert property (
      (wr_go && !hit)
      |=> $stable(O_CH2_OFFSET) && $stable(O_CH2_GAIN)
          && $stable(O_CH3_OFFSET_HIGH) && $stable(regs[4]))
      else $error("Unmapped write changed a register");

endmodule

// ### bench/tb.sv
// Self-checking bench for the channel calibration register bank.
// Assumes the bank acks a classic Wishbone cycle one cycle after taking it.
`timescale 1ns/100ps
module tb;
   logic        clk  = 1'b0;
   logic        rst  = 1'b1;
   logic        cyc  = 1'b0;
   logic        stb  = 1'b0;
   logic        we   = 1'b0;
   logic [7:0]  adr  = 8'h00;
   logic [3:0]  sel  = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic        ack;
   logic [31:0] rdat;
   logic [23:0] ofs2, gain2;
   logic [15:0] ofs3;
   logic [9:0]  chan3_phase_delay;
   logic        dc_off3;
   logic [1:0]  in_sel3;
   logic [15:0] rst_val [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] d;
   int          bad_count = 0;
   int          tests_run = 0;

   acr_regs dut (.I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
      .O_CH2_OFFSET(ofs2), .O_CH2_GAIN(gain2), .O_CH3_OFFSET_HIGH(ofs3),
      .O_CH3_PHASE_DELAY(chan3_phase_delay), .O_CH3_DC_BLOCK_OFF(dc_off3), .O_CH3_INPUT_SELECT(in_sel3));

   always #50 clk = ~clk;

   task automatic stop_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t port %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ack is sampled high or 20 cycles pass; no fixed latency assumed
   task automatic wb(input logic w, input logic [5:0] idx, input logic [3:0] s,
                     input logic [15:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'h0};
      sel  <= s;
      wdat <= {16'hA5A5, wd};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("CHECK FAILED %0t no ack", $time);
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [3:0] s, input logic [15:0] wd);
      logic [31:0] unused;
      wb(1'b1, idx, s, wd, unused);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
      logic [31:0] got;
      wb(1'b0, idx, 4'hF, 16'h0, got);
      chk_bus(got, {16'h0, exp});
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      stop_test();
   end

   initial begin
      do_reset();
      for (int i = 0; i < 6; i++) rd_chk(6'h14 + 6'(i), rst_val[i]);
      chk_port({8'h0, gain2}, 32'h0080_0000);
      chk_port({8'h0, ofs2}, 32'h0);
      chk_port({19'h0, chan3_phase_delay, dc_off3, in_sel3}, 32'h0);
      wr(6'h15, 4'h3, 16'hFFFF);
      rd_chk(6'h15, 16'hFF00);
      wr(6'h14, 4'h3, 16'h8123);
      chk_port({8'h0, ofs2}, 32'h0081_23FF);
      wr(6'h15, 4'h3, 16'h3C00);
      chk_port({8'h0, ofs2}, 32'h0081_233C);
      wr(6'h16, 4'h3, 16'hFFFF);
      wr(6'h17, 4'h3, 16'hABCD);
      rd_chk(6'h17, 16'hAB00);
      chk_port({8'h0, gain2}, 32'h00FF_FFAB);
      wr(6'h16, 4'h1, 16'h0055);
      chk_port({8'h0, gain2}, 32'h00FF_55AB);
      for (int i = 0; i < 4; i++) begin
         d = {10'(10'h201 + i * 93), 3'h7, i[0], i[1:0]};
         wr(6'h18, 4'h3, d);
         rd_chk(6'h18, d & 16'hFFC7);
         chk_port({22'h0, chan3_phase_delay}, {22'h0, d[15:6]});
         chk_port({31'h0, dc_off3}, {31'h0, i[0]});
         chk_port({30'h0, in_sel3}, 32'(i));
      end
      wr(6'h18, 4'h2, 16'h0000);
      rd_chk(6'h18, 16'h0007);
      chk_port({19'h0, chan3_phase_delay, dc_off3, in_sel3}, 32'h0000_0007);
      wr(6'h19, 4'h3, 16'hF00D);
      chk_port({16'h0, ofs3}, 32'h0000_F00D);
      rd_chk(6'h19, 16'hF00D);
      wr(6'h1A, 4'h3, 16'h1234);
      rd_chk(6'h1A, 16'h0000);
      do_reset();
      chk_port({8'h0, gain2}, 32'h0080_0000);
      rd_chk(6'h18, 16'h0000);
      rd_chk(6'h17, 16'h0000);
      rd_chk(6'h16, 16'h8000);
      stop_test();
   end
endmodule
